// ### jtbsi_bscell.sv
// Boundary register: one capture/shift stage and one update latch per pin.
// Fed by enables from the test port controller on sys_clk.
`timescale 1ns/10ps
`default_nettype none
module jtbsi_bscell #(
   parameter int N = 8
) (
   // Clock and reset
   input wire logic sysClk,
   input wire logic reset,
   // Control
   input wire logic capEn,
   input wire logic shEn,
   input wire logic updEn,
   input wire logic serIn,
   input wire logic [N-1:0] pinIn,
   // Results
   output logic serOut,
   output logic [N-1:0] updQ
);
   logic [N-1:0] sh_r, sh_nxt, upd_r, upd_nxt;
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_cell
         always_comb begin
            sh_nxt[i] = sh_r[i];
            if (capEn)
               sh_nxt[i] = pinIn[i];
            else if (shEn)
               sh_nxt[i] = (i == N-1) ? serIn : sh_r[(i+1) % N];
            upd_nxt[i] = updEn ? sh_r[i] : upd_r[i];
         end
      end
   endgenerate
   always_ff @(posedge sysClk or posedge reset) begin
      if (reset) begin
         sh_r <= '0;
         upd_r <= '0;
      end else begin
         sh_r <= sh_nxt;
         upd_r <= upd_nxt;
      end
   end
   assign serOut = sh_r[0];
   assign updQ = upd_r;
endmodule
`default_nettype wire

// ### jtbsi_host.sv
// Scan tester model: drives tck, tms, tdi, trstN and samples tdo.
// Assumes tasks are entered right after a sys_clk rising edge.
`timescale 1ns/10ps
`default_nettype none
module jtbsi_host (
   // Clock
   input wire logic sys_clk,
   // Scan port
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic trstN,
   input wire logic tdo
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      trstN = 1'b0;
   end
   // 160 ns test clock, parked low between frames
   task automatic tick(input logic m, input logic d, output logic q);
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge sys_clk);
      tck <= 1'b1;
      repeat (4) @(posedge sys_clk);
      q = tdo;
      tck <= 1'b0;
   endtask
   task automatic walk(input logic [7:0] seq, input int n);
      logic q;
      for (int i = 0; i < n; i++) begin
         tick(seq[i], ~tdi, q);
      end
   endtask
   task automatic tapReset();
      trstN <= 1'b0;
      repeat (6) @(posedge sys_clk);
      trstN <= 1'b1;
      walk(8'h1f, 6);
   endtask
   // Idle to idle, lsb first; reconfig loads use this path too
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
         output logic [31:0] dout);
      logic q;
      dout = 32'h0;
      walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], q);
         dout[i] = q;
      end
      walk(8'h01, 2);
   endtask
endmodule
`default_nettype wire

// ### jtbsi_pkg.sv
// Shared constants of the scan test port: instruction codes, register
// lengths, reset values and pin-sync depth.
// Assumes one system clock; the test clock is sampled as plain data.
package jtbsi_pkg;
   localparam int IR_LEN = 10;
   localparam int UCODE_LEN = 32;
   localparam int ID_LEN = 32;
   localparam logic [9:0] OP_EXTEST = 10'h000;
   localparam logic [9:0] OP_RECONFIG = 10'h001;
   localparam logic [9:0] OP_SAMPLE = 10'h005;
   localparam logic [9:0] OP_IDCODE = 10'h006;
   localparam logic [9:0] OP_USERCODE = 10'h007;
   localparam logic [9:0] OP_CLAMP = 10'h00a;
   localparam logic [9:0] OP_HIGHZ = 10'h00b;
   localparam logic [9:0] OP_CFGIO = 10'h00d;
   localparam logic [9:0] OP_BYPASS = 10'h3ff;
   // IR capture pattern: two low bits 01 per the scan standard
   localparam logic [9:0] IR_CAPTURE = 10'h001;
   localparam logic [9:0] IR_RESET = OP_IDCODE;
   // Arbitrary neutral identity value, low bit forced to one elsewhere
   localparam logic [31:0] ID_DEFAULT = 32'h0000_0001;
   localparam int SYNC_STAGES = 2;
   typedef enum logic [3:0] {
      JT_RESET = 4'h0, JT_IDLE = 4'h1, JT_SEL_DR = 4'h2, JT_CAP_DR = 4'h3,
      JT_SH_DR = 4'h4, JT_EX1_DR = 4'h5, JT_PAU_DR = 4'h6, JT_EX2_DR = 4'h7,
      JT_UPD_DR = 4'h8, JT_SEL_IR = 4'h9, JT_CAP_IR = 4'ha, JT_SH_IR = 4'hb,
      JT_EX1_IR = 4'hc, JT_PAU_IR = 4'hd, JT_EX2_IR = 4'he, JT_UPD_IR = 4'hf
   } jtbsi_state_t;
endpackage

// ### jtbsi_tap.sv
// Scan test port with boundary, bypass, identity and user code registers.
// Assumes tck, tms, tdi, trstN arrive asynchronously; tck is oversampled.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Scan chain may rewrite pin I/O standards before or in user mode.
// - Sample/preload captures pins and takes pattern for later output.
// - External test drives outputs from boundary, captures inputs.
// - Bypass code puts one-stage bypass between data in and out.
// - User code instruction shifts out the 32-bit user code.
// - Identity instruction shifts out the identity value.
// - Tri-state instruction uses bypass and floats every pin.
// - Clamp uses bypass and holds pins at boundary levels.
// - Reconfig trigger emulates a low pulse on the request pin.
// - I/O-standard load allowed anytime; aborts ongoing configuration.
// - After that, status pin held low until reconfigured.
// - Scan port carries in-circuit reconfiguration instructions.
// - Instruction register is ten bits long.
// - Bus hold or pull-up overrides the forced high impedance.
// - Identity value always has its low bit set.
module jtbsi_tap #(
   parameter int NPINS = 8,
   parameter logic [31:0] ID_VALUE = jtbsi_pkg::ID_DEFAULT
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Scan port pins
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trstN,
   output logic tdo,
   output logic tdoOe,
   // Device pins and core
   input wire logic [NPINS-1:0] pinIn,
   input wire logic [NPINS-1:0] coreOut,
   input wire logic [NPINS-1:0] coreOe,
   input wire logic [NPINS-1:0] keeperEn,
   input wire logic [31:0] userCode,
   input wire logic configBusy,
   input wire logic configDone,
   output logic [NPINS-1:0] pinOut,
   output logic [NPINS-1:0] pinOe,
   output logic [NPINS-1:0] pinKeep,
   // Configuration control
   output logic reconfigReqN,
   output logic configAbort,
   output logic configStatusPinN,
   output logic ioStdLoad
);
   logic [3:0] sy1_r, sy2_r;
   logic tckD_r, tckRise, tckFall;
   jtbsi_pkg::jtbsi_state_t st_r, st_nxt;
   logic [9:0] irSh_r, irSh_nxt, ir_r, ir_nxt;
   logic [31:0] drSh_r, drSh_nxt;
   logic byp_r, byp_nxt;
   logic tdo_r, tdo_nxt, tdoOe_r, tdoOe_nxt;
   logic hold_r, hold_nxt, rcfg_r, rcfg_nxt, abort_r, abort_nxt;
   logic [NPINS-1:0] pOut_r, pOut_nxt, pOe_r, pOe_nxt, pKeep_r, pKeep_nxt;
   logic bsOut;
   logic [NPINS-1:0] bsQ;
   logic sTck, sTms, sTdi, sTrstN;
   logic [NPINS-1:0] pinSy1_r, pinSy2_r;
   logic statN_r;
   logic selBs, selId, selUc, selIr, extest, clamp, highz;

   // Pins are async to sys_clk; first stage feeds only the second
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sy1_r <= 4'h0;
         sy2_r <= 4'h0;
         tckD_r <= 1'b0;
         pinSy1_r <= '0;
         pinSy2_r <= '0;
      end else begin
         sy1_r <= {trstN, tdi, tms, tck};
         sy2_r <= sy1_r;
         tckD_r <= sy2_r[0];
         pinSy1_r <= pinIn;
         pinSy2_r <= pinSy1_r;
      end
   end
   assign sTck = sy2_r[0];
   assign sTms = sy2_r[1];
   assign sTdi = sy2_r[2];
   assign sTrstN = sy2_r[3];
   assign tckRise = sTck & ~tckD_r;
   assign tckFall = ~sTck & tckD_r;

   // Instruction decode; anything undefined falls to bypass
   always_comb begin
      selBs = (ir_r == jtbsi_pkg::OP_SAMPLE) ||
              (ir_r == jtbsi_pkg::OP_EXTEST) ||
              (ir_r == jtbsi_pkg::OP_CFGIO);
      selId = (ir_r == jtbsi_pkg::OP_IDCODE);
      selUc = (ir_r == jtbsi_pkg::OP_USERCODE);
      extest = (ir_r == jtbsi_pkg::OP_EXTEST);
      clamp = (ir_r == jtbsi_pkg::OP_CLAMP);
      highz = (ir_r == jtbsi_pkg::OP_HIGHZ);
      selIr = (st_r == jtbsi_pkg::JT_SH_IR);
   end

   jtbsi_bscell #(.N(NPINS)) u_bs (
      .sysClk(sys_clk),
      .reset(reset),
      .capEn(tckRise && selBs && st_r == jtbsi_pkg::JT_CAP_DR),
      .shEn(tckRise && selBs && st_r == jtbsi_pkg::JT_SH_DR),
      .updEn(tckFall && selBs && ir_r != jtbsi_pkg::OP_CFGIO &&
             st_r == jtbsi_pkg::JT_UPD_DR),
      .serIn(sTdi),
      .pinIn(pinSy2_r),
      .serOut(bsOut),
      .updQ(bsQ)
   );

   // Port state machine advances on rising test clock
   always_comb begin
      st_nxt = st_r;
      if (!sTrstN)
         st_nxt = jtbsi_pkg::JT_RESET;
      else if (tckRise) begin
         case (st_r)
            jtbsi_pkg::JT_RESET: st_nxt = sTms ? jtbsi_pkg::JT_RESET :
                                 jtbsi_pkg::JT_IDLE;
            jtbsi_pkg::JT_IDLE: st_nxt = sTms ? jtbsi_pkg::JT_SEL_DR :
                                jtbsi_pkg::JT_IDLE;
            jtbsi_pkg::JT_SEL_DR: st_nxt = sTms ? jtbsi_pkg::JT_SEL_IR :
                                  jtbsi_pkg::JT_CAP_DR;
            jtbsi_pkg::JT_CAP_DR, jtbsi_pkg::JT_SH_DR:
               st_nxt = sTms ? jtbsi_pkg::JT_EX1_DR : jtbsi_pkg::JT_SH_DR;
            jtbsi_pkg::JT_EX1_DR: st_nxt = sTms ? jtbsi_pkg::JT_UPD_DR :
                                  jtbsi_pkg::JT_PAU_DR;
            jtbsi_pkg::JT_PAU_DR: st_nxt = sTms ? jtbsi_pkg::JT_EX2_DR :
                                  jtbsi_pkg::JT_PAU_DR;
            jtbsi_pkg::JT_EX2_DR: st_nxt = sTms ? jtbsi_pkg::JT_UPD_DR :
                                  jtbsi_pkg::JT_SH_DR;
            jtbsi_pkg::JT_SEL_IR: st_nxt = sTms ? jtbsi_pkg::JT_RESET :
                                  jtbsi_pkg::JT_CAP_IR;
            jtbsi_pkg::JT_CAP_IR, jtbsi_pkg::JT_SH_IR:
               st_nxt = sTms ? jtbsi_pkg::JT_EX1_IR : jtbsi_pkg::JT_SH_IR;
            jtbsi_pkg::JT_EX1_IR: st_nxt = sTms ? jtbsi_pkg::JT_UPD_IR :
                                  jtbsi_pkg::JT_PAU_IR;
            jtbsi_pkg::JT_PAU_IR: st_nxt = sTms ? jtbsi_pkg::JT_EX2_IR :
                                  jtbsi_pkg::JT_PAU_IR;
            jtbsi_pkg::JT_EX2_IR: st_nxt = sTms ? jtbsi_pkg::JT_UPD_IR :
                                  jtbsi_pkg::JT_SH_IR;
            jtbsi_pkg::JT_UPD_DR, jtbsi_pkg::JT_UPD_IR:
               st_nxt = sTms ? jtbsi_pkg::JT_SEL_DR : jtbsi_pkg::JT_IDLE;
            default: st_nxt = jtbsi_pkg::JT_RESET;
         endcase
      end
   end

   // Shift registers and instruction latch
   always_comb begin
      irSh_nxt = irSh_r;
      ir_nxt = ir_r;
      drSh_nxt = drSh_r;
      byp_nxt = byp_r;
      rcfg_nxt = 1'b1;
      abort_nxt = 1'b0;
      hold_nxt = hold_r;
      if (configDone && !configBusy && ir_r != jtbsi_pkg::OP_CFGIO)
         hold_nxt = 1'b0; // Released once a fresh configuration completes
      if (st_r == jtbsi_pkg::JT_RESET)
         ir_nxt = jtbsi_pkg::IR_RESET;
      if (tckRise) begin
         case (st_r)
            jtbsi_pkg::JT_CAP_IR: irSh_nxt = jtbsi_pkg::IR_CAPTURE;
            jtbsi_pkg::JT_SH_IR: irSh_nxt = {sTdi, irSh_r[9:1]};
            jtbsi_pkg::JT_CAP_DR: begin
               byp_nxt = 1'b0;
               if (selId)
                  drSh_nxt = {ID_VALUE[31:1], 1'b1};
               else if (selUc)
                  drSh_nxt = userCode;
            end
            jtbsi_pkg::JT_SH_DR: begin
               byp_nxt = sTdi;
               drSh_nxt = {sTdi, drSh_r[31:1]};
            end
            default: ;
         endcase
      end
      if (tckFall && st_r == jtbsi_pkg::JT_UPD_IR) begin
         ir_nxt = irSh_r;
         if (irSh_r == jtbsi_pkg::OP_RECONFIG)
            rcfg_nxt = 1'b0; // One-cycle emulated low pulse
         if (irSh_r == jtbsi_pkg::OP_CFGIO) begin
            abort_nxt = configBusy;
            hold_nxt = 1'b1;
         end
      end
      // Data-out changes on the falling test clock
      tdo_nxt = tdo_r;
      tdoOe_nxt = tdoOe_r;
      if (tckFall) begin
         tdoOe_nxt = (st_r == jtbsi_pkg::JT_SH_DR) || selIr;
         if (selIr)
            tdo_nxt = irSh_r[0];
         else if (selBs)
            tdo_nxt = bsOut;
         else if (selId || selUc)
            tdo_nxt = drSh_r[0];
         else
            tdo_nxt = byp_r;
      end
      // Test reset silences data-out at once, not at the next fall
      if (!sTrstN)
         tdoOe_nxt = 1'b0;
   end

   // Pin muxing; bus hold and pull-up beat forced float
   always_comb begin
      pOut_nxt = coreOut;
      pOe_nxt = coreOe;
      if (extest || clamp) begin
         pOut_nxt = bsQ;
         pOe_nxt = {NPINS{1'b1}};
      end else if (highz)
         pOe_nxt = '0;
      pKeep_nxt = (extest || clamp || highz) ? keeperEn & ~pOe_nxt : '0;
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         st_r <= jtbsi_pkg::JT_RESET;
         irSh_r <= '0;
         ir_r <= jtbsi_pkg::IR_RESET;
         drSh_r <= '0;
         byp_r <= 1'b0;
         tdo_r <= 1'b0;
         tdoOe_r <= 1'b0;
         hold_r <= 1'b0;
         statN_r <= 1'b1;
         rcfg_r <= 1'b1;
         abort_r <= 1'b0;
         pOut_r <= '0;
         pOe_r <= '0;
         pKeep_r <= '0;
      end else begin
         st_r <= st_nxt;
         irSh_r <= irSh_nxt;
         ir_r <= ir_nxt;
         drSh_r <= drSh_nxt;
         byp_r <= byp_nxt;
         tdo_r <= tdo_nxt;
         tdoOe_r <= tdoOe_nxt;
         hold_r <= hold_nxt;
         statN_r <= ~hold_nxt;
         rcfg_r <= rcfg_nxt;
         abort_r <= abort_nxt;
         pOut_r <= pOut_nxt;
         pOe_r <= pOe_nxt;
         pKeep_r <= pKeep_nxt;
      end
   end

   assign tdo = tdo_r;
   assign tdoOe = tdoOe_r;
   assign pinOut = pOut_r;
   assign pinOe = pOe_r;
   assign pinKeep = pKeep_r;
   assign reconfigReqN = rcfg_r;
   assign configAbort = abort_r;
   // Own flop so the pin carries no gate after the register
   assign configStatusPinN = statN_r;
   assign ioStdLoad = hold_r;
endmodule
`default_nettype wire

// ### jtbsi_tap_sva.sv
// Port checker for the scan test port, bound into every jtbsi_tap.
// Assumes tck is parked low between frames and keeperEn is static.
`timescale 1ns/10ps
`default_nettype none
module jtbsi_tap_sva #(
   parameter int NPINS = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Scan port
   input wire logic tck,
   input wire logic trstN,
   input wire logic tdo,
   input wire logic tdoOe,
   // Pins
   input wire logic [NPINS-1:0] keeperEn,
   input wire logic [NPINS-1:0] pinOe,
   input wire logic [NPINS-1:0] pinKeep,
   // Configuration
   input wire logic configBusy,
   input wire logic configDone,
   input wire logic reconfigReqN,
   input wire logic configAbort,
   input wire logic configStatusPinN,
   input wire logic ioStdLoad
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   a_recfg_pulse:
      assert property (!reconfigReqN |=> reconfigReqN)
      else $error("reconfig request low too long");
   a_abort_pulse:
      assert property (configAbort |=> !configAbort)
      else $error("abort pulse too long");
   a_abort_busy:
      assert property (configAbort |-> $past(configBusy))
      else $error("abort without configuration in progress");
   a_status_hold:
      assert property (!configStatusPinN && !configDone |=> !configStatusPinN)
      else $error("status pin released before configured");
   a_iostd_inv:
      assert property (ioStdLoad == !configStatusPinN)
      else $error("load flag disagrees with status pin");
   // Two cycles of sync delay keep tdo moves inside the tck low phase
   a_tdo_fall:
      assert property ($changed(tdo) |-> !$past(tck, 2))
      else $error("tdo moved outside tck low phase");
   a_keep_en:
      assert property ((pinKeep & ~$past(keeperEn)) == '0)
      else $error("keeper on a pin without keeper enabled");
   a_keep_float:
      assert property ((pinKeep & pinOe) == '0)
      else $error("keeper on a driven pin");
   a_trst_quiet:
      assert property (!trstN [*6] |-> !tdoOe)
      else $error("tdo enabled during test reset");
endmodule
bind jtbsi_tap jtbsi_tap_sva #(.NPINS(NPINS)) u_jtbsi_tap_sva (
   .sys_clk(sys_clk), .reset(reset), .tck(tck), .trstN(trstN),
   .tdo(tdo), .tdoOe(tdoOe), .keeperEn(keeperEn), .pinOe(pinOe),
   .pinKeep(pinKeep), .configBusy(configBusy), .configDone(configDone),
   .reconfigReqN(reconfigReqN), .configAbort(configAbort),
   .configStatusPinN(configStatusPinN), .ioStdLoad(ioStdLoad));
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for jtbsi_tap with the scan tester model.
// Assumes the checker is bound in from its own file.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   // Arbitrary identity value; low bit clear to see it forced
   localparam logic [31:0] ID_VAL = 32'h0a5c_3e10;
   localparam logic [9:0] BYP_OPS [4] = '{jtbsi_pkg::OP_BYPASS,
      jtbsi_pkg::OP_HIGHZ, jtbsi_pkg::OP_CLAMP, 10'h0ff};
   logic sys_clk, reset, tck, tms, tdi, trstN, tdo, tdoOe;
   logic [7:0] pinIn, coreOut, coreOe, keeperEn, pinOut, pinOe, pinKeep;
   logic [31:0] userCode, got;
   logic configBusy, configDone, reconfigReqN, configAbort;
   logic configStatusPinN, ioStdLoad;
   int num_errors = 0;
   int n_checks = 0;
   int nRecfg = 0;
   int nAbort = 0;
   initial sys_clk = 1'b0;
   always #10 sys_clk = ~sys_clk;
   jtbsi_tap #(.NPINS(8), .ID_VALUE(ID_VAL)) u_jtbsi_tap (
      .sys_clk(sys_clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi),
      .trstN(trstN), .tdo(tdo), .tdoOe(tdoOe), .pinIn(pinIn),
      .coreOut(coreOut), .coreOe(coreOe), .keeperEn(keeperEn),
      .userCode(userCode), .configBusy(configBusy),
      .configDone(configDone), .pinOut(pinOut), .pinOe(pinOe),
      .pinKeep(pinKeep), .reconfigReqN(reconfigReqN),
      .configAbort(configAbort), .configStatusPinN(configStatusPinN),
      .ioStdLoad(ioStdLoad));
   jtbsi_host u_jtbsi_host (.sys_clk(sys_clk), .tck(tck), .tms(tms),
      .tdi(tdi), .trstN(trstN), .tdo(tdo));
   always @(posedge sys_clk) begin
      if (reconfigReqN === 1'b0) nRecfg++;
      if (configAbort === 1'b1) nAbort++;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One-stage bypass: a zero leads, then the pattern one bit late
   function automatic logic [31:0] bypExp(input logic [31:0] p);
      return {24'h0, p[6:0], 1'b0};
   endfunction
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic ir(input logic [9:0] op);
      u_jtbsi_host.scan(1'b1, 10, {22'h0, op}, got);
      chk(got, 32'h1);
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      test_done();
   end
   initial begin
      logic [9:0] code;
      logic [31:0] pre;
      logic [31:0] pat;
      int n0;
      reset = 1'b1;
      configBusy = 1'b0;
      configDone = 1'b0;
      {pinIn, coreOut, coreOe, keeperEn} = 32'h0;
      userCode = 32'h0;
      void'($urandom(32'h90f5390a));
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      {pinIn, coreOut, coreOe, keeperEn} <= $urandom;
      userCode <= $urandom;
      @(posedge sys_clk);
      u_jtbsi_host.tapReset();
      u_jtbsi_host.scan(1'b0, 32, 32'hffff_ffff, got);
      chk(got, ID_VAL | 32'h1);
      chk({31'h0, tdoOe}, 32'h0);
      $display("identity test done");
      ir(jtbsi_pkg::OP_USERCODE);
      u_jtbsi_host.scan(1'b0, 32, 32'h0, got);
      chk(got, userCode);
      $display("user code test done");
      ir(jtbsi_pkg::OP_SAMPLE);
      pre = $urandom;
      u_jtbsi_host.scan(1'b0, 8, pre, got);
      chk(got, 32'(pinIn));
      chk(32'(pinOut), 32'(coreOut));
      $display("sample test done");
      for (int i = 0; i < 5; i++) begin
         code = (i == 4) ? {1'b1, 9'($urandom)} : BYP_OPS[i];
         ir(code);
         pat = $urandom;
         u_jtbsi_host.scan(1'b0, 8, pat, got);
         chk(got, bypExp(pat));
         if (code == jtbsi_pkg::OP_HIGHZ) begin
            chk(32'(pinOe), 32'h0);
            chk(32'(pinKeep), 32'(keeperEn));
         end
         if (code == jtbsi_pkg::OP_CLAMP) begin
            chk(32'(pinOut), 32'(pre[7:0]));
         end
      end
      $display("bypass family test done");
      pinIn <= 8'($urandom);
      ir(jtbsi_pkg::OP_EXTEST);
      chk(32'(pinOut), 32'(pre[7:0]));
      pat = $urandom;
      u_jtbsi_host.scan(1'b0, 8, pat, got);
      chk(got, 32'(pinIn));
      chk(32'(pinOut), 32'(pat[7:0]));
      $display("external test done");
      n0 = nRecfg;
      ir(jtbsi_pkg::OP_RECONFIG);
      chk(32'(nRecfg - n0), 32'h1);
      $display("reconfig test done");
      // Second pass loads I/O standards mid-configuration on purpose
      for (int b = 0; b < 2; b++) begin
         n0 = nAbort;
         configBusy <= b[0];
         ir(jtbsi_pkg::OP_CFGIO);
         chk(32'(nAbort - n0), 32'(b));
         // The load stops configuration, so scanning is allowed again
         configBusy <= 1'b0;
         chk({31'h0, ioStdLoad}, 32'h1);
         u_jtbsi_host.scan(1'b0, 8, pat, got);
         chk(got, 32'(pinIn));
         chk(32'(pinOut), 32'(coreOut));
         ir(jtbsi_pkg::OP_BYPASS);
         chk({31'h0, configStatusPinN}, 32'h0);
         configDone <= 1'b1;
         for (int k = 0; k < 8 && configStatusPinN !== 1'b1; k++) begin
            @(posedge sys_clk);
         end
         chk({31'h0, configStatusPinN}, 32'h1);
         configDone <= 1'b0;
      end
      $display("io standard load test done");
      test_done();
   end
endmodule
`default_nettype wire
